// ===== spicd_pkg.sv
// Shared constants and types for the serial clock rate and data port block
package spicd_pkg;
  localparam int BYTE_W = 8;
  localparam logic [7:0] DIV_REG_ADDR = 8'hA2;
  localparam logic [7:0] DATA_REG_ADDR = 8'hA3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int RX_FIFO_DEPTH = 8;
  // Clock period in ns, slave timing figures in system clock periods
  localparam int CORE_CLOCK_NS = 20;
  localparam int SLAVE_OUT_VALID_MAX_CYC = 4;
  localparam int LAST_EDGE_CHANGE_MIN_CYC = 6;
  localparam int LAST_EDGE_CHANGE_MAX_CYC = 8;
  // Edge to output latency through the synchroniser, detect and output flop
  localparam int SLAVE_PIPE_CYC = 4;
  localparam int LAST_EDGE_TARGET_CYC =
    (LAST_EDGE_CHANGE_MIN_CYC + LAST_EDGE_CHANGE_MAX_CYC) / 2;
  localparam logic [1:0] LAST_EDGE_HOLD =
    2'(LAST_EDGE_TARGET_CYC - SLAVE_PIPE_CYC);
  typedef enum logic [0:0] {
    SPICD_IDLE = 1'b0,
    SPICD_RUN = 1'b1
  } spicd_state_t;
endpackage

// ===== spicd_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module spicd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic do_push;
  logic do_pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (do_pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + 1'b1;
      end else if (do_pop && !do_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== spicd_core.sv
// Serial clock divider, data register, buffers and bit engines of the port
//
// How it works
// - Master clock is core clock over 2(div+1)
// - Data register write fills transmit buffer
// - Master write to data register starts transfer
// - Data register read returns receive buffer
// - Polarity select inverts clock in both roles
// - Master clock phases last at least one cycle
// - Slave output driven/released within four cycles
// - Phase-one slave changes output 6-8 after last edge
// - Master samples input one cycle before bit end
// - Slave samples input at bit centre
// - Buffer empty clears on write, sets on move
`timescale 1ns/1ns
`default_nettype none
module spicd_core #(
  parameter int FIFO_DEPTH = spicd_pkg::RX_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [spicd_pkg::BYTE_W-1:0] sfr_wdata,
  output logic [spicd_pkg::BYTE_W-1:0] sfr_rdata,
  input wire logic spi_enable,
  input wire logic master_enable,
  input wire logic clock_polarity_select,
  input wire logic clock_phase_select,
  output logic tx_buffer_empty,
  output logic transfer_done,
  output logic write_collision,
  output logic rx_overrun,
  output logic busy,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic nss_n_in
);
  import spicd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] sck_s;
  logic [1:0] mosi_s;
  logic [1:0] miso_s;
  logic [1:0] nss_n_s;
  logic sck_d_r;
  logic nss_n_d_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sck_s <= 2'h0;
      mosi_s <= 2'h0;
      miso_s <= 2'h0;
      nss_n_s <= 2'h3;
      sck_d_r <= 1'b0;
      nss_n_d_r <= 1'b1;
    end else begin
      sck_s <= {sck_s[0], sck_in};
      mosi_s <= {mosi_s[0], mosi_in};
      miso_s <= {miso_s[0], miso_in};
      nss_n_s <= {nss_n_s[0], nss_n_in};
      sck_d_r <= sck_s[1];
      nss_n_d_r <= nss_n_s[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register access and transmit buffer
  logic [7:0] sck_divider_reg;
  logic [7:0] tx_buf_r;
  logic [7:0] shift_r;
  logic wr_data;
  logic wr_ok;
  logic rd_data;
  logic load_shift;
  logic rx_out_valid;
  logic [7:0] rx_out_data;

  assign wr_data = sfr_wr && (sfr_addr == DATA_REG_ADDR);
  assign wr_ok = wr_data && tx_buffer_empty;
  assign rd_data = sfr_rd && (sfr_addr == DATA_REG_ADDR);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sck_divider_reg <= REG_RESET;
    end else if (sfr_wr && (sfr_addr == DIV_REG_ADDR)) begin
      sck_divider_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_buf_r <= REG_RESET;
      tx_buffer_empty <= 1'b1;
      write_collision <= 1'b0;
    end else begin
      write_collision <= wr_data && !tx_buffer_empty;
      if (wr_ok) begin
        tx_buf_r <= sfr_wdata;
      end
      // A write is only taken while empty, a move only while full
      if (load_shift) begin
        tx_buffer_empty <= 1'b1;
      end else if (wr_ok) begin
        tx_buffer_empty <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= REG_RESET;
    end else if (sfr_rd) begin
      case (sfr_addr)
        DIV_REG_ADDR: sfr_rdata <= sck_divider_reg;
        DATA_REG_ADDR: sfr_rdata <= rx_out_valid ? rx_out_data : REG_RESET;
        default: sfr_rdata <= REG_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master engine
  spicd_state_t state_r;
  logic [7:0] div_lat_r;
  logic [7:0] half_cnt_r;
  logic half_r;
  logic [2:0] m_bits_r;
  logic m_start;
  logic m_sample;
  logic m_done;
  logic rx_ready;

  // No start while the receive queue is full: a finished master byte is never lost
  assign m_start = spi_enable && master_enable && (state_r == SPICD_IDLE) &&
                   !tx_buffer_empty && rx_ready;
  assign m_sample = (state_r == SPICD_RUN) && half_r &&
                    (half_cnt_r == div_lat_r);
  assign m_done = m_sample && (m_bits_r == BIT_LAST);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= SPICD_IDLE;
      div_lat_r <= REG_RESET;
      half_cnt_r <= 8'h00;
      half_r <= 1'b0;
      m_bits_r <= 3'h0;
    end else begin
      case (state_r)
        SPICD_IDLE: begin
          if (m_start) begin
            state_r <= SPICD_RUN;
            div_lat_r <= sck_divider_reg;
            half_cnt_r <= 8'h00;
            half_r <= 1'b0;
            m_bits_r <= 3'h0;
          end
        end
        SPICD_RUN: begin
          // Each half lasts div+1 cycles, never less than one
          if (half_cnt_r == div_lat_r) begin
            half_cnt_r <= 8'h00;
            half_r <= ~half_r;
            if (half_r) begin
              m_bits_r <= m_bits_r + 3'h1;
              if (m_bits_r == BIT_LAST) begin
                state_r <= SPICD_IDLE;
              end
            end
          end else begin
            half_cnt_r <= half_cnt_r + 8'h01;
          end
        end
        default: state_r <= SPICD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slave engine
  logic s_act;
  logic s_lvl;
  logic s_lvl_d;
  logic s_sample;
  logic s_last;
  logic s_sel_fall;
  logic [2:0] s_bits_r;
  logic [1:0] hold_r;

  assign s_act = spi_enable && !master_enable && !nss_n_s[1];
  assign s_sel_fall = s_act && nss_n_d_r;
  assign s_lvl = sck_s[1] ^ clock_polarity_select;
  assign s_lvl_d = sck_d_r ^ clock_polarity_select;
  // Sample edge sits mid-bit: leading for phase 0, trailing for phase 1
  assign s_sample = s_act && !s_sel_fall &&
                    (clock_phase_select ? (s_lvl_d && !s_lvl)
                                        : (s_lvl && !s_lvl_d));
  assign s_last = s_sample && (s_bits_r == BIT_LAST);
  assign load_shift = m_start ||
                      ((s_sel_fall || s_last) && !tx_buffer_empty);

  // The outside master keeps select-to-edge and phase widths
  // so the two-flop synchroniser sees every edge in order
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_bits_r <= 3'h0;
    end else if (!s_act || s_sel_fall) begin
      s_bits_r <= 3'h0;
    end else if (s_sample) begin
      s_bits_r <= s_bits_r + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hold_r <= 2'h0;
    end else if (s_last && clock_phase_select) begin
      hold_r <= LAST_EDGE_HOLD;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and receive queue
  logic rx_push;
  logic [7:0] rx_byte;

  assign rx_byte = master_enable ? {shift_r[6:0], miso_s[1]}
                                 : {shift_r[6:0], mosi_s[1]};
  assign rx_push = m_done || s_last;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      shift_r <= REG_RESET;
    end else if (load_shift) begin
      shift_r <= tx_buf_r;
    end else if (m_sample || s_sample) begin
      shift_r <= rx_byte;
    end
  end

  spicd_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(core_clk),
    .rstn(rstn),
    .in_valid(rx_push),
    .in_ready(rx_ready),
    .in_data(rx_byte),
    .out_valid(rx_out_valid),
    .out_ready(rd_data),
    .out_data(rx_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers and status
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sck_out <= ((state_r == SPICD_RUN) &&
                  (half_r ^ clock_phase_select)) ^
                 clock_polarity_select;
      sck_oe <= spi_enable && master_enable;
      mosi_out <= shift_r[7];
      mosi_oe <= spi_enable && master_enable;
      if (hold_r == 2'h0 && !(s_last && clock_phase_select)) begin
        miso_out <= shift_r[7];
      end
      miso_oe <= s_act;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      transfer_done <= 1'b0;
      rx_overrun <= 1'b0;
      busy <= 1'b0;
    end else begin
      transfer_done <= rx_push;
      // Slave cannot be held off, so a full queue drops the byte
      rx_overrun <= s_last && !rx_ready;
      busy <= (state_r == SPICD_RUN) || m_start || (s_act && !nss_n_d_r);
    end
  end
endmodule
`default_nettype wire

// ===== spicd_props.sv
// Port assertions for the serial clock rate and data port
`timescale 1ns/1ns
`default_nettype none
module spicd_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic spi_enable,
  input wire logic master_enable,
  input wire logic clock_polarity_select,
  input wire logic tx_buffer_empty,
  input wire logic write_collision,
  input wire logic busy,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic miso_oe,
  input wire logic nss_n_in
);
  import spicd_pkg::*;
  logic [7:0] div_r;
  logic wd;
  logic go;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  assign wd = sfr_wr && sfr_addr == DATA_REG_ADDR;
  // Start also needs queue room; the queue only fills in slave frames here
  assign go = wd && tx_buffer_empty && spi_enable && master_enable && !busy;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) div_r <= REG_RESET;
    else if (sfr_wr && sfr_addr == DIV_REG_ADDR) div_r <= sfr_wdata;
  end
  ////////////////////////////////////////
  chk_empty_clear: assert property (wd && tx_buffer_empty |=>
    !tx_buffer_empty) else $error("empty flag kept");
  chk_move_empty: assert property (go |-> ##[2:3] tx_buffer_empty)
    else $error("buffer not moved");
  chk_wcol_pulse: assert property (wd && !tx_buffer_empty |=>
    write_collision) else $error("no collision pulse");
  chk_start_busy: assert property (go |-> ##[1:3] busy)
    else $error("no master start");
  chk_sck_idle: assert property (sck_oe && !busy && !$past(busy) &&
    $stable(clock_polarity_select) |-> sck_out == clock_polarity_select)
    else $error("idle clock level");
  chk_miso_on: assert property ($fell(nss_n_in) && spi_enable &&
    !master_enable |-> ##[1:4] miso_oe) else $error("slave output late");
  chk_miso_off: assert property ($rose(nss_n_in) && !master_enable |->
    ##[1:4] !miso_oe) else $error("slave output held");
  chk_div_read: assert property (sfr_rd && sfr_addr == DIV_REG_ADDR |=>
    sfr_rdata == div_r) else $error("divider readback");
  cover property (go);
  cover property ($fell(nss_n_in) && !master_enable);
  cover property (wd && !tx_buffer_empty);
endmodule
bind spicd_core spicd_props spicd_props_inst (.core_clk, .rstn, .sfr_addr,
  .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .spi_enable, .master_enable,
  .clock_polarity_select, .tx_buffer_empty, .write_collision, .busy,
  .sck_out, .sck_oe, .miso_oe, .nss_n_in);
`default_nettype wire

// ===== spicd_slave_model.sv
// Behavioural outside SPI slave for the master role
`timescale 1ns/1ns
`default_nettype none
module spicd_slave_model (
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic pol,
  input wire logic pha,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh;
  initial miso = 1'h0;
  always @(negedge sel_n) begin
    sh = tx << !pha;
    miso = pha ? miso : tx[7];
  end
  // Deselected line flips so a stale bit never reads as good
  always @(posedge sel_n) miso = ~miso;
  always @(sck) begin
    if (!sel_n && ((sck != pol) ^ pha)) begin
      rx = {rx[6:0], mosi};
    end else if (!sel_n) begin
      miso = sh[7];
      sh = sh << 1;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the serial clock rate and data port
`timescale 1ns/1ns
`default_nettype none
`define CK(w, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  err_count++; $display("BAD %s exp %h got %h", w, e, s); end end
module tb;
  import spicd_pkg::*;
  typedef struct packed {
    logic [7:0] div;
    logic pol;
    logic pha;
    logic [7:0] tx;
    logic [7:0] rx;
  } spicd_row_t;
  // All-ones reply on the fastest rate survives the input synchroniser lag
  spicd_row_t rows [4] = '{'{8'h00, 1'h0, 1'h0, 8'hA5, 8'hFF},
    '{8'h01, 1'h1, 1'h0, 8'h81, 8'hC3}, '{8'h03, 1'h1, 1'h1, 8'h01, 8'h80},
    '{8'hFF, 1'h0, 1'h1, 8'hC6, 8'h5A}};
  logic core_clk = 1'h0, rstn = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
  logic spi_enable = 1'h1, master_enable = 1'h1, pol = 1'h0, pha = 1'h0;
  logic tb_sck = 1'h0, tb_mosi = 1'h0, nss_n = 1'h1, sel_n = 1'h1, ps;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, m_tx = 8'h00;
  logic [7:0] sfr_rdata, m_rx, d, sb = 8'h4B, st = 8'h96;
  logic tx_buffer_empty, transfer_done, write_collision, busy, m_miso;
  logic rx_overrun, ov = 1'h0;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  int err_count = 0, cmp_count = 0, cyc = 0, hc = 0, hl = 0;
  wire logic sck_pin = sck_oe ? sck_out : tb_sck;
  wire logic mosi_pin = mosi_oe ? mosi_out : tb_mosi;
  wire logic miso_pin = miso_oe ? miso_out : m_miso;
  spicd_core spicd_core_inst (.core_clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .spi_enable, .master_enable,
    .clock_polarity_select(pol), .clock_phase_select(pha), .tx_buffer_empty,
    .transfer_done, .write_collision, .rx_overrun, .busy,
    .sck_in(sck_pin), .sck_out, .sck_oe, .mosi_in(mosi_pin), .mosi_out,
    .mosi_oe, .miso_in(miso_pin), .miso_out, .miso_oe, .nss_n_in(nss_n));
  spicd_slave_model spicd_slave_model_inst (.sel_n, .sck(sck_pin),
    .mosi(mosi_pin), .pol, .pha, .tx(m_tx), .miso(m_miso), .rx(m_rx));
  always #10 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic conclude;
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // About 5700 cycles in all, the slowest row 4200; the ceiling leaves room
  always @(posedge core_clk) begin
    cyc++;
    hc++;
    if (sck_out !== ps) begin
      hl = hc;
      hc = 0;
    end
    ps = sck_out;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input int n);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'h1;
    repeat (n) @(negedge core_clk);
    sfr_wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'h1;
    @(negedge core_clk);
    sfr_rd = 1'h0;
    d = sfr_rdata;
  endtask
  // Overrun is a one-cycle pulse; keep it until the bench looks
  always @(negedge core_clk) begin
    if (rx_overrun === 1'h1) ov = 1'h1;
  end
  // Outside master frame; data moves at select, on the shift edge and at deselect, so the
  // sample edge never meets a changing data line
  task automatic slv(input logic p, input logic q, input logic [7:0] o,
    input logic [7:0] i);
    pha = p;
    pol = q;
    tb_sck = q;
    wr(DATA_REG_ADDR, o, 1);
    nss_n = 1'h0;
    for (int b = 7; b >= 0; b--) begin
      if (!p) tb_mosi = i[b];
      repeat (6) @(negedge core_clk);
      `CK("slave out", o[b], miso_pin)
      tb_sck = ~q;
      if (p) tb_mosi = i[b];
      repeat (6) @(negedge core_clk);
      tb_sck = q;
    end
    repeat (6) @(negedge core_clk);
    if (p) `CK("late hold", o[0], miso_pin)
    repeat (2) @(negedge core_clk);
    if (p) `CK("late change", i[7], miso_pin)
    nss_n = 1'h1;
    tb_mosi = ~tb_mosi;
    repeat (6) @(negedge core_clk);
    `CK("slave oe", 1'h0, miso_oe)
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    rstn = 1'h1;
    `CK("empty", 1'h1, tx_buffer_empty)
    rd(DIV_REG_ADDR);
    `CK("div reset", REG_RESET, d)
    rd(DATA_REG_ADDR);
    `CK("data reset", REG_RESET, d)
    rd(8'h55);
    `CK("unmapped", 8'h00, d)
    wr(DIV_REG_ADDR, rows[0].div, 1);
    foreach (rows[i]) begin
      pol = rows[i].pol;
      pha = rows[i].pha;
      m_tx = rows[i].rx;
      repeat (2) @(negedge core_clk);
      sel_n = 1'h0;
      wr(DATA_REG_ADDR, rows[i].tx, 2);
      wr(DIV_REG_ADDR, rows[(i + 1) % 4].div, 1);
      do @(negedge core_clk); while (transfer_done !== 1'h1);
      repeat (3) @(negedge core_clk);
      sel_n = 1'h1;
      `CK("half", 9'(rows[i].div) + 9'h001, hl[8:0])
      `CK("sent", rows[i].tx, m_rx)
      rd(DATA_REG_ADDR);
      `CK("received", rows[i].rx, d)
    end
    master_enable = 1'h0;
    slv(1'h0, 1'h0, st, sb);
    rd(DATA_REG_ADDR);
    `CK("slave in", sb, d)
    slv(1'h1, 1'h1, 8'h69, 8'h5E);
    rd(DATA_REG_ADDR);
    `CK("slave in", 8'h5E, d)
    for (int k = 0; k < 8; k++) slv(1'h0, 1'h0, st, 8'(k));
    `CK("no overrun", 1'h0, ov)
    slv(1'h0, 1'h0, st, 8'hEE);
    `CK("overrun", 1'h1, ov)
    for (int k = 0; k < 8; k++) begin
      rd(DATA_REG_ADDR);
      `CK("queued", 8'(k), d)
    end
    rd(DATA_REG_ADDR);
    `CK("dropped", REG_RESET, d)
    slv(1'h0, 1'h0, st, sb);
    wr(DIV_REG_ADDR, 8'h5A, 1);
    wr(DATA_REG_ADDR, st, 1);
    `CK("written", 1'h0, tx_buffer_empty)
    rstn = 1'h0;
    repeat (2) @(negedge core_clk);
    `CK("reset empty", 1'h1, tx_buffer_empty)
    rstn = 1'h1;
    rd(DIV_REG_ADDR);
    `CK("div reset", REG_RESET, d)
    rd(DATA_REG_ADDR);
    `CK("data reset", REG_RESET, d)
    conclude();
  end
endmodule
`default_nettype wire
